// ### src/wdt_top.sv
// module: watchdog with prescaler, service location, cause flag and reset pin drive
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module wdt_top
  import wdt_pkg::*;
(
  input wire logic clk,                       // crystal clock, 200 MHz
  input wire logic arst_n,                    // asynchronous reset, active low
  input wire bus_req_t bus,                   // cpu register access
  input wire logic [DATA_W-1:0] vector_lo,    // low byte of the reset vector
  input wire sys_in_t sys,                    // mode and reset context
  output logic [DATA_W-1:0] rdata,            // read data, cycle after the strobe
  output logic rst_pin_n,                     // external reset pin drive
  output logic watchdog_disable,              // disable signal from configuration
  output logic wdt_reset                      // one-cycle system reset request
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [PRE_W-1:0] pre;        // system_prescaler
    logic [CNT_W-1:0] cnt;        // watchdog counter
    logic [POR_W-1:0] por;        // power-up cycle count
    logic por_done;               // power-up clear already given
    logic cfg_disable;            // configuration disable bit
    logic cause;                  // watchdog_cause_flag
    logic fire;                   // overflow reset request
    logic [DATA_W-1:0] rdata;     // read data holder
  } wdt_state_t;

  wdt_state_t st_reg;             // registered state
  wdt_state_t st_next;            // next state

  // ****************************************************************
  // decode and conditions
  // ****************************************************************
  logic svc_wr;                   // write to the service location
  logic cfg_wr;                   // write to the configuration register
  logic cause_rd;                 // read of the reset cause register
  logic test_off;                 // test voltage conditions turn the watchdog off
  logic disabled;                 // watchdog may not reset the part
  logic pre_clear;                // whole prescaler cleared this cycle
  logic tick;                     // watchdog counter advances
  logic overflow;                 // counter wraps with reset allowed
  logic por_hit;                  // power-up delay just elapsed

  // address decode; reads never touch the watchdog counters
  always_comb begin
    svc_wr = bus.wr && (bus.addr == ADDR_SERVICE);
    cfg_wr = bus.wr && (bus.addr == ADDR_CONFIG);
    cause_rd = bus.rd && (bus.addr == ADDR_CAUSE);
  end

  // disable sources, any one is enough
  always_comb begin
    test_off = sys.monitor_mode && (sys.hv_on_irq || sys.hv_on_rst);
    test_off = test_off || (sys.break_active && sys.hv_on_rst);
    disabled = st_reg.cfg_disable || test_off;
  end

  // clear events and count tick
  always_comb begin
    por_hit = !st_reg.por_done && (st_reg.por == POR_LAST);
    pre_clear = sys.internal_reset || sys.vector_fetch || por_hit || st_reg.fire;
    // wait mode is not an input, so the count simply runs on
    tick = !sys.stop_mode && (st_reg.pre[TAP_W-1:0] == TAP_ALL);
    // overflow after 64 ticks of 4096 cycles
    overflow = tick && (st_reg.cnt == CNT_MAX) && !disabled && !svc_wr
               && !sys.internal_reset;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  // one process for every field; the order of the ifs is the priority
  always_comb begin
    st_next = st_reg;
    st_next.fire = 1'b0;
    st_next.rdata = DATA_ZERO;

    // power-up counter runs once, then rests
    if (!st_reg.por_done) begin
      if (por_hit) begin
        st_next.por_done = 1'b1;
      end else begin
        st_next.por = st_reg.por + 1'b1;
      end
    end

    if (pre_clear) begin
      st_next.pre = '0;
    end else if (svc_wr) begin
      // partial prescaler clear
      // low four bits keep running, hence the 2^4 shortfall on timeout
      st_next.pre = st_reg.pre + 1'b1;
      st_next.pre[PRE_CLR_HI:PRE_CLR_LO] = '0;
    end else if (!sys.stop_mode) begin
      st_next.pre = st_reg.pre + 1'b1;
    end

    // watchdog counter: clears win over counting
    if (sys.internal_reset || st_reg.fire) begin
      st_next.cnt = '0;
    end else if (svc_wr) begin
      st_next.cnt = '0;
    end else if (disabled) begin
      st_next.cnt = '0;
    end else if (tick) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end

    // overflow: request the reset and note the cause
    if (overflow) begin
      st_next.fire = 1'b1;
    end

    // configuration disable bit, written at its own address
    if (cfg_wr) begin
      st_next.cfg_disable = bus.wdata[CFG_DISABLE_BIT];
    end

    // cause flag: read clears, but a new overflow in that cycle wins
    if (cause_rd) begin
      st_next.cause = 1'b0;
    end
    if (overflow) begin
      st_next.cause = 1'b1;
    end

    // read data, valid only in the cycle after the strobe
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_SERVICE: st_next.rdata = vector_lo;
        ADDR_CONFIG: st_next.rdata = DATA_W'(st_reg.cfg_disable) << CFG_DISABLE_BIT;
        ADDR_CAUSE: st_next.rdata = DATA_W'(st_reg.cause) << CAUSE_WDT_BIT;
        default: st_next.rdata = DATA_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // the whole state struct in one register bank
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // disable follows the configuration bit through its own flop
  logic disable_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      disable_reg <= 1'b0;
    end else begin
      disable_reg <= st_next.cfg_disable;
    end
  end

  // ****************************************************************
  // reset pin drive
  // ****************************************************************
  // pin pulse on overflow
  wdt_pin_stretch u_stretch (
    .clk(clk),
    .arst_n(arst_n),
    .fire(st_reg.fire),
    .pin_n(rst_pin_n),
    .busy()
  );

  // outputs; the only action is a reset, there is no interrupt port
  assign rdata = st_reg.rdata;
  assign wdt_reset = st_reg.fire;
  assign watchdog_disable = disable_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_service_count: assert property (@(posedge clk) disable iff (!arst_n)
    svc_wr |=> (st_reg.cnt == '0) && !wdt_reset)
    else $error("service write did not clear the counter");

  a_service_prescaler: assert property (@(posedge clk) disable iff (!arst_n)
    (svc_wr && !pre_clear) |=> (st_reg.pre[PRE_CLR_HI:PRE_CLR_LO] == '0)
      && (st_reg.pre[PRE_CLR_LO-1:0] == $past(st_reg.pre[PRE_CLR_LO-1:0]) + 1'b1))
    else $error("service write did not clear prescaler bits 12..4");

  a_vector_read: assert property (@(posedge clk) disable iff (!arst_n)
    (bus.rd && bus.addr == ADDR_SERVICE) |=> (rdata == $past(vector_lo)))
    else $error("service location did not read the vector byte");

  a_overflow_cause: assert property (@(posedge clk) disable iff (!arst_n)
    overflow |=> wdt_reset && st_reg.cause ##1 !rst_pin_n)
    else $error("overflow did not set cause or drop the pin");

  a_disabled_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    disabled |=> !wdt_reset && (st_reg.cnt == '0))
    else $error("disabled watchdog counted or fired");

  a_test_voltage: assert property (@(posedge clk) disable iff (!arst_n)
    (sys.monitor_mode && sys.hv_on_irq) || (sys.break_active && sys.hv_on_rst)
      |-> disabled)
    else $error("test voltage did not disable the watchdog");

  a_stop_freeze: assert property (@(posedge clk) disable iff (!arst_n)
    (sys.stop_mode && !pre_clear && !svc_wr && !disabled)
      |=> $stable(st_reg.pre) && $stable(st_reg.cnt))
    else $error("count moved in stop mode");

  a_running_count: assert property (@(posedge clk) disable iff (!arst_n)
    (!sys.stop_mode && !pre_clear && !svc_wr) |=> st_reg.pre == $past(st_reg.pre) + 1'b1)
    else $error("prescaler did not advance");

  a_fetch_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (sys.vector_fetch || sys.internal_reset) |=> st_reg.pre == '0)
    else $error("prescaler not cleared on fetch or internal reset");

  a_power_up: assert property (@(posedge clk) disable iff (!arst_n)
    por_hit |=> (st_reg.pre == '0) && st_reg.por_done)
    else $error("power-up clear missing");

  a_disable_follow: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr |=> ##1 (watchdog_disable == $past(bus.wdata[CFG_DISABLE_BIT], 2)))
    else $error("disable output did not follow the bit");

  // the request must not linger, or the pin stretch would restart
  a_fire_one_cycle: assert property (@(posedge clk) disable iff (!arst_n)
    wdt_reset |=> !wdt_reset)
    else $error("reset request longer than one cycle");

  // a request only ever comes from a real overflow
  a_fire_from_overflow: assert property (@(posedge clk) disable iff (!arst_n)
    wdt_reset |-> $past(overflow))
    else $error("reset request without overflow");

  // the overflow acts as an internal reset on both counters
  a_fire_clears_counts: assert property (@(posedge clk) disable iff (!arst_n)
    wdt_reset |=> (st_reg.cnt == '0) && (st_reg.pre == '0))
    else $error("counters not cleared after the reset request");

  // internal reset clears the watchdog counter too
  a_internal_count_clear: assert property (@(posedge clk) disable iff (!arst_n)
    sys.internal_reset |=> (st_reg.cnt == '0))
    else $error("internal reset did not clear the counter");

  // one step per tick, wrap at the top is the overflow itself
  a_tick_step: assert property (@(posedge clk) disable iff (!arst_n)
    (tick && !disabled && !svc_wr && !sys.internal_reset && !st_reg.fire)
      |=> (st_reg.cnt == $past(st_reg.cnt) + 1'b1))
    else $error("counter did not step on a tick");

  // between ticks the counter must rest
  a_no_tick_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (!tick && !disabled && !svc_wr && !sys.internal_reset && !st_reg.fire)
      |=> $stable(st_reg.cnt))
    else $error("counter moved without a tick");

  // with the prescaler clock gated no overflow can be raised
  a_stop_no_fire: assert property (@(posedge clk) disable iff (!arst_n)
    sys.stop_mode |=> !wdt_reset)
    else $error("reset request raised in stop mode");

  // read data stand one cycle only, then the idle value
  a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !bus.rd |=> (rdata == DATA_ZERO))
    else $error("read data not idle without a strobe");

  // the cause survives until software reads it
  a_cause_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.cause && !cause_rd) |=> st_reg.cause)
    else $error("cause flag lost without a read");

  // a read clears the cause unless a new overflow lands at once
  a_cause_read_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (cause_rd && !overflow) |=> !st_reg.cause)
    else $error("cause flag not cleared by its read");

  // the stored disable bit takes the written value
  a_disable_config: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr |=> (st_reg.cfg_disable == $past(bus.wdata[CFG_DISABLE_BIT])))
    else $error("configuration disable bit not stored");

  // monitor test voltage on the reset pin also silences the counter
  a_monitor_rst_voltage: assert property (@(posedge clk) disable iff (!arst_n)
    (sys.monitor_mode && sys.hv_on_rst) |=> (st_reg.cnt == '0))
    else $error("monitor test voltage did not hold the counter");

endmodule : wdt_top
`default_nettype wire

// ### src/wdt_pkg.sv
// package: register map, field layout and timing constants of the watchdog
// Operation
// - 6-bit counter behind 13-bit prescaler, crystal clocked
// - unserviced overflow resets after 2^18-2^4 cycles
// - any write to service location restarts timeout
// - overflow drives pin low 32 cycles, flags cause
// - service write also clears prescaler bits 12..4
// - service location reads reset vector low byte
// - prescaler cleared 4096 cycles after power-up
// - internal reset clears prescaler and watchdog counter
// - reset vector fetch clears the prescaler
// - disable signal follows configuration disable bit
// - watchdog never raises a CPU interrupt
// - monitor mode with test voltage disables watchdog
// - watchdog keeps counting during wait mode
// - stop mode freezes prescaler and watchdog count
// - break with test voltage on reset disables
// - timebase is the crystal clock itself
package wdt_pkg;

  // ****************************************************************
  // bus and register map
  // ****************************************************************
  localparam int ADDR_W = 16;               // cpu address width
  localparam int DATA_W = 8;                // cpu data width
  localparam logic [ADDR_W-1:0] ADDR_SERVICE = 16'hffff; // service / vector low byte
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 16'hfe00;  // disable bit lives here
  localparam logic [ADDR_W-1:0] ADDR_CAUSE = 16'hfe01;   // reset cause register
  localparam int CFG_DISABLE_BIT = 0;       // watchdog_disable position
  localparam int CAUSE_WDT_BIT = 0;         // watchdog_cause_flag position
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00; // unmapped and idle read value

  // ****************************************************************
  // counter geometry and timing
  // ****************************************************************
  localparam int PRE_W = 13;                // system_prescaler width
  localparam int CNT_W = 6;                 // watchdog counter width
  localparam int PRE_CLR_LO = 4;            // lowest prescaler bit cleared on service
  localparam int PRE_CLR_HI = 12;           // highest prescaler bit cleared on service
  localparam int TAP_W = 12;                // low prescaler bits that form one tick period
  localparam logic [TAP_W-1:0] TAP_ALL = 12'h0fff; // tick when these are all ones
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;    // last count before overflow
  localparam int POR_CYCLES = 4096;         // prescaler clear after power-up
  localparam int POR_W = 13;                // room for the power-up count
  localparam logic [POR_W-1:0] POR_LAST = 13'(POR_CYCLES);
  localparam int PIN_CYCLES = 32;           // reset pin low time in crystal cycles
  localparam int PIN_W = 6;                 // room for the pin count
  localparam logic [PIN_W-1:0] PIN_LAST = 6'(PIN_CYCLES - 1);

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;  // byte address
    logic [DATA_W-1:0] wdata; // write data
    logic wr;                 // one-cycle write strobe
    logic rd;                 // one-cycle read strobe
  } bus_req_t;

  typedef struct packed {
    logic monitor_mode;   // part runs in monitor mode
    logic hv_on_irq;      // test voltage sensed on interrupt pin
    logic hv_on_rst;      // test voltage sensed on reset pin
    logic break_active;   // break interrupt in progress
    logic stop_mode;      // stop mode, prescaler clock gated
    logic vector_fetch;   // reset vector fetch on the data bus
    logic internal_reset; // any internal reset source
  } sys_in_t;

endpackage : wdt_pkg

// ### src/wdt_pin_stretch.sv
// module: stretches a one-cycle reset request into a timed low pulse on the reset pin
`timescale 1ns/100ps
`default_nettype none
module wdt_pin_stretch
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fire,        // one-cycle watchdog overflow
  output logic pin_n,           // reset pin drive, low while active
  output logic busy             // pulse in progress
);

  // ****************************************************************
  // state
  // ****************************************************************
  // the pin level lives in the flop itself, so the output has no gate behind it
  typedef struct packed {
    logic pin_n;                // reset pin level, low while the pulse runs
    logic [PIN_W-1:0] cnt;      // cycles already low
  } stretch_t;

  stretch_t st_reg;             // registered state
  stretch_t st_next;            // next state

  // next-state logic; a fresh request during a pulse restarts the count
  always_comb begin
    st_next = st_reg;
    if (fire) begin
      st_next.pin_n = 1'b0;
      st_next.cnt = '0;
    end else if (!st_reg.pin_n) begin
      if (st_reg.cnt == PIN_LAST) begin
        st_next.pin_n = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // pin released high while in reset
      st_reg <= '{pin_n: 1'b1, cnt: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_n = st_reg.pin_n;
  assign busy = !st_reg.pin_n;

  // count low cycles to check the pulse width
  logic [PIN_W:0] low_run;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_run <= '0;
    end else begin
      low_run <= pin_n ? '0 : low_run + 1'b1;
    end
  end

  a_pin_low_width: assert property (@(posedge clk) disable iff (!arst_n)
    ($rose(pin_n) && !$past(fire)) |-> (low_run == (PIN_W+1)'(PIN_CYCLES)))
    else $error("reset pin low time wrong");

  a_pin_drops_fire: assert property (@(posedge clk) disable iff (!arst_n)
    fire |=> !pin_n [*8])
    else $error("reset pin did not go low after overflow");

endmodule : wdt_pin_stretch
`default_nettype wire

// ### tb/wdt_cpu_model.sv
// partner model: cpu core side, supplies the reset vector and fetches it after reset
`timescale 1ns/100ps
`default_nettype none
module wdt_cpu_model
  import wdt_pkg::*;
#(
  parameter logic [DATA_W-1:0] VECTOR_LO = 8'h5a // arbitrary vector byte
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rst_pin_n,
  output logic [DATA_W-1:0] vector_lo,
  output logic vector_fetch
);
  // ****************************************************************
  // reset vector and fetch
  // ****************************************************************
  logic pin_q; // reset pin level one cycle back

  // vector byte is a fixed level, as a rom word would be
  assign vector_lo = VECTOR_LO;

  // cpu leaves reset on the pin's rising edge and fetches the vector one cycle later
  // vector fetch after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= 1'b1;
      vector_fetch <= 1'b0;
    end else begin
      pin_q <= rst_pin_n;
      vector_fetch <= rst_pin_n & ~pin_q;
    end
  end
endmodule : wdt_cpu_model
`default_nettype wire

// ### tb/testbench.sv
// testbench: drives the watchdog over its register port and times one full overflow
`timescale 1ns/100ps
`default_nettype none
module testbench
  import wdt_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [DATA_W-1:0] VEC = 8'h5a; // arbitrary vector byte
  localparam int LO = 2**18 - 16 + 1000;      // shortest timeout plus frozen stretch
  localparam int HI = 2**18 + 1000 + 4;       // longest, with a little latency slack
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  bus_req_t bus = '0;           // register port request
  sys_in_t sys_tb = '0;         // mode inputs driven here
  sys_in_t sys_w;               // mode inputs plus the model's fetch
  logic vfetch;                 // fetch from the cpu model
  logic [DATA_W-1:0] vec_lo;
  logic [DATA_W-1:0] rdata;
  logic rst_pin_n;
  logic wd_dis;
  logic wdt_reset;
  int n_errors = 0;
  int n_checks = 0;
  int cnt;

  // 200 MHz crystal clock
  always #2.5 clk = ~clk;

  // the model owns only the fetch field
  always_comb begin
    sys_w = sys_tb;
    sys_w.vector_fetch = vfetch;
  end

  wdt_top uut (
    .clk(clk), .arst_n(arst_n), .bus(bus), .vector_lo(vec_lo), .sys(sys_w),
    .rdata(rdata), .rst_pin_n(rst_pin_n), .watchdog_disable(wd_dis), .wdt_reset(wdt_reset)
  );

  wdt_cpu_model #(.VECTOR_LO(VEC)) cpu (
    .clk(clk), .arst_n(arst_n), .rst_pin_n(rst_pin_n),
    .vector_lo(vec_lo), .vector_fetch(vfetch)
  );

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // a gap edge before each strobe keeps back-to-back calls from colliding
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : bus_write

  // read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                          input string what);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask : bus_read

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    #1;
    check("reset_rdata", rdata, 16'h0000);
    check("reset_pin", rst_pin_n, 16'h0001);
    check("reset_disable", wd_dis, 16'h0000);
    check("reset_pulse", wdt_reset, 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
    // service location reads back the vector byte, then idles at zero
    bus_read(ADDR_SERVICE, VEC, "service_read");
    @(posedge clk);
    #1;
    check("rdata_idle", rdata, 16'h0000);
    // unmapped place: write ignored, read zero
    bus_write(16'h1234, 8'hff);
    bus_read(16'h1234, DATA_ZERO, "unmapped_read");
    // disable output follows the configuration bit one cycle after the write
    bus_write(ADDR_CONFIG, 8'h01);
    @(posedge clk);
    #1;
    check("disable_set", wd_dis, 16'h0001);
    bus_read(ADDR_CONFIG, 8'h01, "config_read");
    bus_write(ADDR_CONFIG, 8'h00);
    @(posedge clk);
    #1;
    check("disable_clear", wd_dis, 16'h0000);
    bus_read(ADDR_CAUSE, 8'h00, "cause_idle");
    // test voltage phases; the wait after them lets the power-up clear pass
    @(posedge clk);
    sys_tb.monitor_mode <= 1'b1;
    sys_tb.hv_on_irq <= 1'b1;
    repeat (20) @(posedge clk);
    sys_tb.hv_on_irq <= 1'b0;
    sys_tb.hv_on_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_tb.monitor_mode <= 1'b0;
    sys_tb.break_active <= 1'b1;
    repeat (20) @(posedge clk);
    sys_tb.break_active <= 1'b0;
    sys_tb.hv_on_rst <= 1'b0;
    #1;
    check("disable_cfg_only", wd_dis, 16'h0000);
    repeat (POR_CYCLES) @(posedge clk);
    // start clean, then service with a small prescaler residue
    @(posedge clk);
    sys_tb.internal_reset <= 1'b1;
    @(posedge clk);
    sys_tb.internal_reset <= 1'b0;
    repeat (98) @(posedge clk);
    // service comes from the main sequence, never from a handler
    bus_write(ADDR_SERVICE, 8'ha5);
    // time the overflow; a stop stretch in the middle must freeze the count
    cnt = 0;
    while (wdt_reset !== 1'b1 && cnt < HI + 100) begin
      @(posedge clk);
      cnt++;
      if (cnt == 1000) begin
        sys_tb.stop_mode <= 1'b1;
      end else if (cnt == 2000) begin
        sys_tb.stop_mode <= 1'b0;
      end
      #1;
    end
    check("timeout_window", 16'(cnt >= LO && cnt <= HI), 16'h0001);
    // pulse lasts one cycle and the pin goes low for a fixed count
    @(posedge clk);
    #1;
    check("pulse_width", wdt_reset, 16'h0000);
    cnt = 0;
    while (rst_pin_n === 1'b0 && cnt < 100) begin
      cnt++;
      @(posedge clk);
      #1;
    end
    check("pin_low_cycles", 16'(cnt), 16'(PIN_CYCLES));
    // cause flag set by the overflow, cleared by reading it
    bus_read(ADDR_CAUSE, 8'h01, "cause_set");
    bus_read(ADDR_CAUSE, 8'h00, "cause_cleared");
    // service right before and right after a stop stretch
    bus_write(ADDR_SERVICE, 8'h00);
    @(posedge clk);
    sys_tb.stop_mode <= 1'b1;
    repeat (20) @(posedge clk);
    sys_tb.stop_mode <= 1'b0;
    bus_write(ADDR_SERVICE, 8'h00);
    @(posedge clk);
    #1;
    check("no_reset_around_stop", wdt_reset, 16'h0000);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
